// ==== lb_pkg.sv ====
// Purpose: shared constants for the configurable logic block
// Assumes: 32-bit APB, one word per register
// Notes:   offsets are byte addresses
package lb_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int N_MC = 16;
    localparam int N_IO = 8;
    localparam int N_GCLK = 4;
    localparam int N_BCLK = 4;
    localparam int N_CAND = 8;
    localparam int N_BIN = 33;
    localparam int N_ISM_SRC = 32;
    localparam int N_ISM = 24;
    localparam int N_EXT = 36;
    localparam int N_POOL = 64;
    localparam int N_LOGIC_PT = 80;
    localparam int N_OE_PT = 8;
    localparam int N_INIT_PT = 2;
    localparam int N_PT = 90;
    localparam int PT_PER_MC = 5;
    localparam int MAX_PT_PER_FN = 20;
    localparam int OE_PT_BASE = 80;
    localparam int INIT_PT_BASE = 88;
    localparam int MC_CFG_W = 17;
    localparam int IO_CFG_W = 6;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] CLKSEL_OFS = 12'h004;
    localparam logic [11:0] TERM_IDX_OFS = 12'h00C;
    localparam logic [11:0] TERM_TRUE_OFS = 12'h010;
    localparam logic [11:0] TERM_COMP_OFS = 12'h014;
    localparam logic [11:0] TERM_HI_OFS = 12'h018;
    localparam logic [11:0] STATUS_OFS = 12'h01C;
    localparam logic [11:0] MC_CFG_OFS = 12'h040;
    localparam logic [11:0] IO_CFG_OFS = 12'h080;
    localparam logic [11:0] ISM_OFS = 12'h100;
    localparam logic [11:0] CSM_OFS = 12'h200;

    // ----------------------------------------
    // fields
    // ----------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SWAP = 1;
    localparam int MC_ASYNC = 0;
    localparam int MC_COMB = 1;
    localparam int MC_INV = 2;
    localparam int MC_TYPE = 3;
    localparam int MC_LATCH = 5;
    localparam int MC_BCLK = 6;
    localparam int MC_PTCLK = 8;
    localparam int MC_PTFALL = 9;
    localparam int MC_IPRE = 10;
    localparam int MC_XOR = 11;
    localparam int MC_KEEP = 12;
    localparam int MC_REL = 13;
    localparam int MC_NB = 14;
    localparam int IO_MCSEL = 0;
    localparam int IO_LATCH = 3;
    localparam int IO_BCLK = 4;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [11:0] CLKSEL_RST = 12'h688;
    localparam logic [MC_CFG_W-1:0] MC_CFG_RST = 17'h01000;
    localparam logic [IO_CFG_W-1:0] IO_CFG_RST = 6'h00;
    localparam logic [N_BIN-1:0] TERM_RST = 33'h1FFFFFFFF;

    typedef enum logic [1:0] {
        FF_D = 2'h0,
        FF_T = 2'h1,
        FF_JK = 2'h2,
        FF_SR = 2'h3
    } ff_type_e;
endpackage

// ==== lb_clkgen.sv ====
// Purpose: block clock generator, four picks from eight candidates
// Assumes: clock pins synchronous to pclk
// Notes:   rising edges become one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module lb_clkgen
    import lb_pkg::*;
(
    // system
    input wire logic pclk,
    input wire logic presetn,
    // pins and selection
    input wire logic [N_GCLK-1:0] gclk_pin,
    input wire logic [3*N_BCLK-1:0] clksel,
    // block clocks
    output logic [N_BCLK-1:0] blk_clk,
    output logic [N_BCLK-1:0] blk_rise
);
    logic [N_BCLK-1:0] blk_prev_q;

    genvar k;
    generate
        for (k = 0; k < N_BCLK; k++)
        begin : g_bclk
            wire logic [2:0] sel = clksel[3*k +: 3];
            // candidate = pin true or inverted
            assign blk_clk[k] = gclk_pin[sel[1:0]] ^ sel[2];
            assign blk_rise[k] = blk_clk[k] & ~blk_prev_q[k];
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    blk_prev_q[k] <= 1'b0;
                else
                    blk_prev_q[k] <= blk_clk[k];
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== lb_macrocell.sv ====
// Purpose: one macrocell, register or latch or combinational
// Assumes: configuration static while run is high
// Notes:   init overrides the registered output at once
`timescale 1ns/1ps
`default_nettype none
module lb_macrocell
    import lb_pkg::*;
(
    // system
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    // configuration
    input wire logic [MC_CFG_W-1:0] cfg,
    // terms
    input wire logic sum,
    input wire logic alt,
    input wire logic pt_clk,
    input wire logic pt_init,
    // block clocks and init
    input wire logic [N_BCLK-1:0] blk_clk,
    input wire logic [N_BCLK-1:0] blk_rise,
    input wire logic init_rst,
    input wire logic init_pre,
    // result
    output logic mc_out
);
    logic q_q;
    logic ptc_prev_q;

    wire logic async_m = cfg[MC_ASYNC];
    wire ff_type_e ftype = ff_type_e'(cfg[MC_TYPE +: 2]);
    wire logic [1:0] bsel = cfg[MC_BCLK +: 2];
    wire logic use_pt = async_m & cfg[MC_PTCLK];
    wire logic fall = cfg[MC_PTFALL];
    wire logic pt_evt = fall ? (~pt_clk & ptc_prev_q) : (pt_clk & ~ptc_prev_q);
    wire logic evt = use_pt ? pt_evt : blk_rise[bsel];
    wire logic gate = use_pt ? (pt_clk ^ fall) : blk_clk[bsel];
    wire logic d_in = cfg[MC_XOR] ? (sum ^ alt) : sum;
    // sync cells share block init, async cells use own term
    wire logic rst = async_m ? (pt_init & ~cfg[MC_IPRE]) : init_rst;
    wire logic pre = async_m ? (pt_init & cfg[MC_IPRE]) : init_pre;
    logic nxt;
    logic q_d;

    always_comb
    begin
        case (ftype)
            FF_D: nxt = d_in;
            FF_T: nxt = q_q ^ d_in;
            FF_JK: nxt = (sum & ~q_q) | (~alt & q_q);
            FF_SR: nxt = sum | (~alt & q_q);
            default: nxt = d_in;
        endcase
    end

    always_comb
    begin
        q_d = q_q;
        if (rst)
            q_d = 1'b0;
        else if (pre)
            q_d = 1'b1;
        else if (run && cfg[MC_LATCH] && gate)
            q_d = d_in;
        else if (run && !cfg[MC_LATCH] && evt)
            q_d = nxt;
    end

    // combinational or registered path, both invertible
    assign mc_out = (cfg[MC_COMB] ? d_in : (rst ? 1'b0 : (pre ? 1'b1 : q_q))) ^ cfg[MC_INV];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_q <= 1'b0;
            ptc_prev_q <= 1'b0;
        end
        else
        begin
            q_q <= q_d;
            ptc_prev_q <= pt_clk;
        end
    end
endmodule
`default_nettype wire

// ==== lb_block.sv ====
// Purpose: configurable logic block with APB configuration port
// Assumes: pins synchronous to pclk; one clock domain
// Notes:   configuration writes refused while run is set
//
// Summary of operation
// - four block clocks, each picked from eight true or inverted pin candidates.
// - every macrocell and I/O cell may use any block clock.
// - term array gives 80 logic, eight enable and two init terms.
// - each macrocell owns five logic terms, lendable to neighbours.
// - one macrocell function may gather up to 20 terms, with XOR.
// - a macrocell lending terms keeps one for its own logic unless its MC_REL bit is set.
// - each I/O driver enabled by its own dedicated term.
// - either block init term initialises all sync-mode flip-flops together.
// - block init acts at once, without a clock edge.
// - sync or async mode chosen per macrocell, independently.
// - registered or combinational output, polarity invertible in both.
// - register acts as D, T, JK, SR flip-flop or latch.
// - 16 macrocells, 8 I/O cells, output matrix steers cells to pins.
// - input matrix picks 24 of 16 feedbacks, 8 registered, 8 pin signals.
// - central matrix delivers 33 signals into the term array.
// - clock pins also usable as plain inputs.
// - async cells may clock on either edge of a term clock.
// - async cell's own init term drives reset or preset.
// - swap bit picks which block init term resets and which presets.
`timescale 1ns/1ps
`default_nettype none
module lb_block
    import lb_pkg::*;
(
    // system
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic [N_GCLK-1:0] gclk_pin,
    input wire logic [N_IO-1:0] io_pin_in,
    output logic [N_IO-1:0] io_pin_out,
    output logic [N_IO-1:0] io_pin_oe,
    // central matrix
    input wire logic [N_EXT-1:0] csm_ext,
    output logic [N_ISM-1:0] ism_to_csm
);
    // ----------------------------------------
    // configuration state
    // ----------------------------------------
    logic [1:0] ctrl_q;
    logic [11:0] clksel_q;
    logic [6:0] term_idx_q;
    logic [N_BIN-1:0] pt_true_q [N_PT];
    logic [N_BIN-1:0] pt_comp_q [N_PT];
    logic [MC_CFG_W-1:0] mc_cfg_q [N_MC];
    logic [IO_CFG_W-1:0] io_cfg_q [N_IO];
    logic [4:0] ism_sel_q [N_ISM];
    logic [5:0] csm_sel_q [N_BIN];
    logic [31:0] prdata_q;
    logic [N_IO-1:0] io_reg_q;
    logic [N_IO-1:0] io_out_q;
    logic [N_IO-1:0] io_oe_q;
    logic [N_ISM-1:0] ism_q;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire logic run = ctrl_q[CTRL_RUN];
    wire logic setup = psel & ~penable;
    wire logic acc = psel & penable;
    wire logic hit_ctrl = paddr == CTRL_OFS;
    wire logic hit_clksel = paddr == CLKSEL_OFS;
    wire logic hit_tidx = paddr == TERM_IDX_OFS;
    wire logic hit_ttrue = paddr == TERM_TRUE_OFS;
    wire logic hit_tcomp = paddr == TERM_COMP_OFS;
    wire logic hit_thi = paddr == TERM_HI_OFS;
    wire logic hit_status = paddr == STATUS_OFS;
    wire logic hit_mc = paddr[11:6] == MC_CFG_OFS[11:6];
    wire logic hit_io = paddr[11:5] == IO_CFG_OFS[11:5];
    wire logic hit_ism = (paddr[11:8] == ISM_OFS[11:8]) && (paddr[7:2] < 6'(N_ISM));
    wire logic hit_csm = (paddr[11:9] == CSM_OFS[11:9]) && (paddr[8:2] < 7'(N_BIN));
    wire logic idx_ok = term_idx_q < 7'(N_PT);
    wire logic hit_term = hit_ttrue | hit_tcomp | hit_thi;
    wire logic mapped = (paddr[1:0] == 2'h0) & (hit_ctrl | hit_clksel | hit_tidx | hit_term | hit_status
                        | hit_mc | hit_io | hit_ism | hit_csm);
    // settings locked while running
    wire logic locked = run & ~hit_ctrl;
    wire logic wr_err = pwrite & (locked | hit_status);
    wire logic wr_ok = acc & pwrite & mapped & ~wr_err & (paddr[1:0] == 2'h0);
    wire logic [3:0] mc_idx = paddr[5:2];
    wire logic [2:0] io_idx = paddr[4:2];
    wire logic [5:0] ism_idx = paddr[7:2];
    wire logic [6:0] csm_idx = paddr[8:2];
    wire logic [6:0] tix = idx_ok ? term_idx_q : 7'h00;

    assign pready = 1'b1;
    assign pslverr = acc & (~mapped | wr_err);
    assign prdata = prdata_q;

    // ----------------------------------------
    // block logic signals
    // ----------------------------------------
    logic [N_BCLK-1:0] blk_clk;
    logic [N_BCLK-1:0] blk_rise;
    logic [N_BIN-1:0] blk_in;
    logic [N_PT-1:0] pt;
    logic [N_MC-1:0] mc_out;
    logic [N_MC-1:0] mc_sum;
    logic [4:0] nb_terms [N_MC];
    wire logic [N_ISM_SRC-1:0] ism_src = {io_pin_in, io_reg_q, mc_out};
    wire logic [N_POOL-1:0] pool = {csm_ext, gclk_pin, ism_q};
    wire logic init_a = pt[INIT_PT_BASE];
    wire logic init_b = pt[INIT_PT_BASE + 1];
    wire logic init_rst = ctrl_q[CTRL_SWAP] ? init_b : init_a;
    wire logic init_pre = ctrl_q[CTRL_SWAP] ? init_a : init_b;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = 32'h00000000;
        if (hit_ctrl)
            rd_val = {30'h0, ctrl_q};
        else if (hit_clksel)
            rd_val = {20'h0, clksel_q};
        else if (hit_tidx)
            rd_val = {25'h0, term_idx_q};
        else if (hit_ttrue && idx_ok)
            rd_val = pt_true_q[tix][31:0];
        else if (hit_tcomp && idx_ok)
            rd_val = pt_comp_q[tix][31:0];
        else if (hit_thi && idx_ok)
            rd_val = {30'h0, pt_comp_q[tix][32], pt_true_q[tix][32]};
        else if (hit_status)
            rd_val = {8'h0, io_oe_q, mc_out};
        else if (hit_mc)
            rd_val = {15'h0, mc_cfg_q[mc_idx]};
        else if (hit_io)
            rd_val = {26'h0, io_cfg_q[io_idx]};
        else if (hit_ism)
            rd_val = {27'h0, ism_sel_q[ism_idx[4:0]]};
        else if (hit_csm)
            rd_val = {26'h0, csm_sel_q[csm_idx[5:0]]};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h00000000;
        else if (setup && !pwrite)
            prdata_q <= rd_val;
    end

    // ----------------------------------------
    // global registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RST;
            clksel_q <= CLKSEL_RST;
            term_idx_q <= 7'h00;
        end
        else if (wr_ok)
        begin
            if (hit_ctrl)
                ctrl_q <= pwdata[1:0];
            if (hit_clksel)
                clksel_q <= pwdata[11:0];
            if (hit_tidx)
                term_idx_q <= pwdata[6:0];
        end
    end

    // ----------------------------------------
    // product-term array
    // ----------------------------------------
    genvar t;
    generate
        for (t = 0; t < N_PT; t++)
        begin : g_pt
            wire logic sel_t = wr_ok & idx_ok & (term_idx_q == 7'(t));
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pt_true_q[t] <= TERM_RST;
                    pt_comp_q[t] <= TERM_RST;
                end
                else if (sel_t && hit_ttrue)
                    pt_true_q[t][31:0] <= pwdata;
                else if (sel_t && hit_tcomp)
                    pt_comp_q[t][31:0] <= pwdata;
                else if (sel_t && hit_thi)
                begin
                    pt_true_q[t][32] <= pwdata[0];
                    pt_comp_q[t][32] <= pwdata[1];
                end
            end
            // and of selected true and complement literals
            assign pt[t] = &((~pt_true_q[t] | blk_in) & (~pt_comp_q[t] | ~blk_in));
        end
    endgenerate

    // ----------------------------------------
    // clock generator
    // ----------------------------------------
    lb_clkgen u_clkgen (
        .pclk(pclk),
        .presetn(presetn),
        .gclk_pin(gclk_pin),
        .clksel(clksel_q),
        .blk_clk(blk_clk),
        .blk_rise(blk_rise)
    );

    // ----------------------------------------
    // logic allocator and macrocells
    // ----------------------------------------
    genvar m;
    generate
        for (m = 0; m < N_MC; m++)
        begin : g_mc
            wire logic [MC_CFG_W-1:0] cfg = mc_cfg_q[m];
            wire logic [4:0] own = pt[PT_PER_MC*m +: PT_PER_MC];
            wire logic async_m = cfg[MC_ASYNC];
            wire logic t0_alt = cfg[MC_XOR] | (cfg[MC_TYPE +: 2] == FF_JK) | (cfg[MC_TYPE +: 2] == FF_SR);
            // terms 3 and 4 become clock and init in async mode
            wire logic [4:0] own_mask = {{2{cfg[MC_KEEP] & ~async_m}}, {2{cfg[MC_KEEP]}},
                                         ~cfg[MC_REL] & ~t0_alt};
            wire logic [2:0] nb = cfg[MC_NB +: 3];
            logic s_lo;
            logic s_hi1;
            logic s_hi2;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    mc_cfg_q[m] <= MC_CFG_RST;
                else if (wr_ok && hit_mc && mc_idx == 4'(m))
                    mc_cfg_q[m] <= pwdata[MC_CFG_W-1:0];
            end
            // lenders keep term 0 unless released
            assign nb_terms[m] = cfg[MC_REL] ? own : {own[4:1], 1'b0};
            if (m > 0)
            begin : g_lo
                assign s_lo = nb[0] & (|nb_terms[m-1]);
            end
            else
            begin : g_lo0
                assign s_lo = 1'b0;
            end
            if (m < N_MC - 1)
            begin : g_h1
                assign s_hi1 = nb[1] & (|nb_terms[m+1]);
            end
            else
            begin : g_h10
                assign s_hi1 = 1'b0;
            end
            if (m < N_MC - 2)
            begin : g_h2
                assign s_hi2 = nb[2] & (|nb_terms[m+2]);
            end
            else
            begin : g_h20
                assign s_hi2 = 1'b0;
            end
            // own five plus three neighbours: up to 20 terms
            assign mc_sum[m] = (|(own & own_mask)) | s_lo | s_hi1 | s_hi2;
            lb_macrocell u_mc (
                .pclk(pclk),
                .presetn(presetn),
                .run(run),
                .cfg(cfg),
                .sum(mc_sum[m]),
                .alt(own[0]),
                .pt_clk(own[3]),
                .pt_init(own[4]),
                .blk_clk(blk_clk),
                .blk_rise(blk_rise),
                .init_rst(init_rst),
                .init_pre(init_pre),
                .mc_out(mc_out[m])
            );
        end
    endgenerate

    // ----------------------------------------
    // I/O cells and output switch matrix
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < N_IO; i++)
        begin : g_io
            wire logic [IO_CFG_W-1:0] cfg = io_cfg_q[i];
            wire logic [1:0] bsel = cfg[IO_BCLK +: 2];
            // pin i reaches macrocells 2i .. 2i+7, wrapping
            wire logic [3:0] mc_sel = 4'(2 * i) + {1'b0, cfg[IO_MCSEL +: 3]};
            wire logic cap = cfg[IO_LATCH] ? blk_clk[bsel] : blk_rise[bsel];
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    io_cfg_q[i] <= IO_CFG_RST;
                else if (wr_ok && hit_io && io_idx == 3'(i))
                    io_cfg_q[i] <= pwdata[IO_CFG_W-1:0];
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    io_reg_q[i] <= 1'b0;
                    io_out_q[i] <= 1'b0;
                    io_oe_q[i] <= 1'b0;
                end
                else
                begin
                    if (run && cap)
                        io_reg_q[i] <= io_pin_in[i];
                    io_out_q[i] <= mc_out[mc_sel];
                    io_oe_q[i] <= run & pt[OE_PT_BASE + i];
                end
            end
        end
    endgenerate

    assign io_pin_out = io_out_q;
    assign io_pin_oe = io_oe_q;

    // ----------------------------------------
    // input and central switch matrices
    // ----------------------------------------
    genvar j;
    generate
        for (j = 0; j < N_ISM; j++)
        begin : g_ism
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    ism_sel_q[j] <= 5'h00;
                    ism_q[j] <= 1'b0;
                end
                else
                begin
                    if (wr_ok && hit_ism && ism_idx == 6'(j))
                        ism_sel_q[j] <= pwdata[4:0];
                    ism_q[j] <= ism_src[ism_sel_q[j]];
                end
            end
        end
        for (j = 0; j < N_BIN; j++)
        begin : g_csm
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    csm_sel_q[j] <= 6'h00;
                else if (wr_ok && hit_csm && csm_idx == 7'(j))
                    csm_sel_q[j] <= pwdata[5:0];
            end
            assign blk_in[j] = pool[csm_sel_q[j]];
        end
    endgenerate

    assign ism_to_csm = ism_q;
endmodule
`default_nettype wire

// ==== lb_block_asserts.sv ====
// Purpose: bus and lock checks on the logic block ports
// Assumes: zero-wait apb slave, one clock domain
// Notes:   run bit tracked from observed ctrl writes
`timescale 1ns/1ps
`default_nettype none
module lb_block_chk
    import lb_pkg::*;
(
    // system
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and matrix
    input wire logic [N_GCLK-1:0] gclk_pin,
    input wire logic [N_IO-1:0] io_pin_in,
    input wire logic [N_IO-1:0] io_pin_out,
    input wire logic [N_IO-1:0] io_pin_oe,
    input wire logic [N_EXT-1:0] csm_ext,
    input wire logic [N_ISM-1:0] ism_to_csm
);
    logic run_q;
    logic run_d;
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    assign run_d = (wr && paddr == CTRL_OFS) ? pwdata[CTRL_RUN] : run_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_q <= 1'b0;
        else
            run_q <= run_d;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_lock_refuse: assert property (wr && run_q && paddr != CTRL_OFS |-> pslverr)
        else $error("config write accepted while running");
    chk_ctrl_open: assert property (acc && paddr == CTRL_OFS |-> !pslverr)
        else $error("ctrl access refused");
    chk_status_ro: assert property (wr && paddr == STATUS_OFS |-> pslverr)
        else $error("status write accepted");
    chk_misalign_err: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access accepted");
    chk_err_phase: assert property (pslverr |-> acc)
        else $error("error outside access phase");
    chk_oe_idle: assert property (!run_q && !$past(run_q) |-> io_pin_oe == '0)
        else $error("pin enabled while stopped");
    chk_oe_stop: assert property (wr && paddr == CTRL_OFS && !pwdata[CTRL_RUN] |-> ##2 io_pin_oe == '0)
        else $error("pin enable survives stop");
    chk_rdata_hold: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
        else $error("read data moved without read");
endmodule
bind lb_block lb_block_chk chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gclk_pin(gclk_pin),
    .io_pin_in(io_pin_in), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe), .csm_ext(csm_ext),
    .ism_to_csm(ism_to_csm));
`default_nettype wire

// ==== lb_board.sv ====
// Purpose: board logic around the block pins
// Assumes: clock pins move on pclk edges
// Notes:   released io pins pulled high
`timescale 1ns/1ps
`default_nettype none
module lb_board
(
    // control
    input wire logic pclk,
    input wire logic [3:0] clk_lvl,
    // pins
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    output logic [3:0] gclk_pin,
    output logic [7:0] io_pin_in,
    output logic [35:0] csm_ext
);
    initial gclk_pin = 4'h0;
    initial csm_ext = 36'h0;
    always @(posedge pclk)
    begin
        gclk_pin <= clk_lvl;
        csm_ext <= {csm_ext[34:0], ~csm_ext[35]};
    end
    assign io_pin_in = (pin_out & pin_oe) | ~pin_oe;
endmodule
`default_nettype wire

// ==== tb_logic_block_clock_init_fabric.sv ====
// Purpose: self-checking bench for the logic block
// Assumes: zero-wait apb slave
// Notes:   board model drives clock and io pins
`timescale 1ns/1ps
`default_nettype none
module tb_logic_block_clock_init_fabric
    import lb_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, inv, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] gclk_pin, g, clk_lvl = 0;
    logic [7:0] io_pin_in, io_pin_out, io_pin_oe;
    logic [35:0] csm_ext;
    logic [23:0] ism_to_csm;
    logic [3:0] seq [4] = '{4'h6, 4'h2, 4'h4, 4'h0};
    logic want [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    int error_cnt = 0, checks_done = 0, cyc = 0, p, i, m, off, prev = 0;
    lb_block dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gclk_pin(gclk_pin),
        .io_pin_in(io_pin_in), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe), .csm_ext(csm_ext),
        .ism_to_csm(ism_to_csm));
    lb_board board (.pclk(pclk), .clk_lvl(clk_lvl), .pin_out(io_pin_out), .pin_oe(io_pin_oe),
        .gclk_pin(gclk_pin), .io_pin_in(io_pin_in), .csm_ext(csm_ext));
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic want_bit(logic [3:0] gl, int pin, logic iv);
        return gl[pin] ^ iv;
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        check(pslverr, err);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic term(input int idx, input logic [32:0] t, input logic [32:0] c);
        apb(1, TERM_IDX_OFS, idx, 0);
        apb(1, TERM_TRUE_OFS, t[31:0], 0);
        apb(1, TERM_COMP_OFS, c[31:0], 0);
        apb(1, TERM_HI_OFS, {30'h0, c[32], t[32]}, 0);
    endtask
    initial
    begin
        void'($urandom(38928));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, CLKSEL_OFS, 0, 0);
        check(rd, 32'(CLKSEL_RST));
        apb(0, MC_CFG_OFS, 0, 0);
        check(rd, 32'(MC_CFG_RST));
        apb(0, 12'hFFC, 0, 1);
        apb(0, 12'h002, 0, 1);
        apb(1, STATUS_OFS, 0, 1);
        apb(1, MC_CFG_OFS + 12'h014, 32'h1001, 0);
        apb(1, CSM_OFS, 24, 0);
        term(89, 1, 0);
        clk_lvl <= 4'h1;
        repeat (8) @(posedge pclk);
        apb(0, STATUS_OFS, 0, 0);
        check(rd[15:0], 16'hFFDF);
        check(ism_to_csm, 24'hFFFFFF);
        apb(1, CTRL_OFS, 2, 0);
        apb(0, STATUS_OFS, 0, 0);
        check(rd[15:0], 16'h0000);
        term(89, '1, '1);
        apb(1, CTRL_OFS, 0, 0);
        apb(1, CLKSEL_OFS, 32'h6B0, 0);
        apb(1, MC_CFG_OFS + 12'h004, 32'h1040, 0);
        apb(1, CSM_OFS + 12'h004, 25, 0);
        term(5, 2, 0);
        apb(1, CTRL_OFS, 1, 0);
        for (int k = 0; k < 4; k++)
        begin
            clk_lvl <= seq[k];
            repeat (8) @(posedge pclk);
            apb(0, STATUS_OFS, 0, 0);
            if (k > 0)
                check(rd[1], want[k]);
        end
        repeat (12)
        begin
            p = $urandom_range(3);
            inv = 1'($urandom_range(1));
            i = $urandom_range(7);
            off = $urandom_range(7);
            m = (2 * i + off) % 16;
            g = 4'($urandom_range(15));
            apb(1, CTRL_OFS, 0, 0);
            term(80 + prev, '1, '1);
            term(5 * m, 1, 0);
            term(80 + i, 1, 0);
            apb(1, CSM_OFS, 24 + p, 0);
            apb(1, MC_CFG_OFS + 12'(4 * m), 32'h1002 | {29'h0, inv, 2'h0}, 0);
            apb(1, IO_CFG_OFS + 12'(4 * i), off, 0);
            apb(1, CTRL_OFS, 1, 0);
            clk_lvl <= g;
            repeat (8) @(posedge pclk);
            e = want_bit(g, p, inv);
            check(io_pin_oe, 32'(g[p]) << i);
            check(io_pin_out[i], e);
            apb(0, STATUS_OFS, 0, 0);
            check(rd[m], e);
            check(rd[23:16], 32'(g[p]) << i);
            apb(1, MC_CFG_OFS, 0, 1);
            prev = i;
        end
        conclude();
    end
endmodule
`default_nettype wire
